// *** design/scp_defines.vh ***
// constants for the command path parser
// Contract
// - power-up and reset command return path to root
// - message terminator returns path to root
// - colon between mnemonics descends one level
// - leading colon restarts resolution at root
// - semicolon separates commands, path kept
// - common commands decode independent of path
// - mnemonic matching ignores letter case
// - newline, EOI, or both end messages
// - EOI byte is the message's last byte
// - short form equals long form
// - optional nodes may be omitted
// - responses end with newline plus EOI
`ifndef SCP_DEFINES_VH
`define SCP_DEFINES_VH

// ==========================================================
// characters
`define SCP_CH_NL 8'h0A
`define SCP_CH_SPACE 8'h20
`define SCP_CH_DQUOTE 8'h22
`define SCP_CH_SQUOTE 8'h27
`define SCP_CH_STAR 8'h2A
`define SCP_CH_COLON 8'h3A
`define SCP_CH_SEMI 8'h3B
`define SCP_CH_QUERY 8'h3F
`define SCP_CASE_BIT 8'h20

// ==========================================================
// keyword table
`define SCP_KW_MAX 4'hA
`define SCP_KW_BITS 80
`define SCP_TAB_N 37
`define SCP_NODE_ROOT 6'h00
`define SCP_CC_RST 6'h1E
`define SCP_ACC_BOTH 2'h0
`define SCP_ACC_NOQUERY 2'h1
`define SCP_ACC_QONLY 2'h2

// table entry fields
`define SCP_F_PAR 97:92
`define SCP_F_OPT 91
`define SCP_F_COM 90
`define SCP_F_ACC 89:88
`define SCP_F_SLEN 87:84
`define SCP_F_FLEN 83:80
`define SCP_F_TEXT 79:0

`endif

// *** design/scp_kw_match.v ***
// keyword table lookup for the command path parser
`timescale 1ns/100ps
`include "scp_defines.vh"

module scp_kw_match (
  input wire [79:0] kw_text,   // upper-cased mnemonic, first char in top byte
  input wire [3:0] kw_len,     // characters held
  input wire kw_common,        // mnemonic follows an asterisk
  input wire [5:0] kw_node,    // working node the mnemonic resolves under
  output reg m_hit,            // table entry found
  output reg [5:0] m_id,       // matched node or common command
  output wire [5:0] m_par,     // parent node of the match
  output wire [1:0] m_acc,     // allowed forms of the match
  output wire m_popt,          // parent node may be omitted
  output wire [5:0] m_gpar     // parent of the parent node
);

  integer i;
  reg [97:0] e;
  reg [97:0] p;
  wire [97:0] e_hit;
  wire [97:0] e_par;

  function [97:0] mk;
    input [5:0] par;
    input opt;
    input com;
    input [1:0] acc;
    input [3:0] sl;
    input [3:0] fl;
    input [79:0] txt;
    begin
      mk = {par, opt, com, acc, sl, fl, txt << (8 * (10 - fl))};
    end
  endfunction

  // the shortened form is the leading part of the long spelling
  function [79:0] pre_mask;
    input [3:0] n;
    begin
      pre_mask = ~({80{1'b1}} >> (8 * n));
    end
  endfunction

  function [97:0] kw_tab;
    input [5:0] idx;
    begin
      case (idx)
        6'h01: kw_tab = mk(6'h00, 1'b1, 1'b0, 2'h0, 4'h4, 4'h5, "SENSE");
        6'h02: kw_tab = mk(6'h01, 1'b0, 1'b0, 2'h0, 4'h4, 4'h7, "AVERAGE");
        6'h03: kw_tab = mk(6'h02, 1'b0, 1'b0, 2'h0, 4'h4, 4'h5, "COUNT");
        6'h04: kw_tab = mk(6'h02, 1'b1, 1'b0, 2'h0, 4'h4, 4'h5, "STATE");
        6'h05: kw_tab = mk(6'h01, 1'b0, 1'b0, 2'h0, 4'h4, 4'hA, "FIMPEDANCE");
        6'h06: kw_tab = mk(6'h05, 1'b0, 1'b0, 2'h0, 4'h4, 4'h8, "APERTURE");
        6'h07: kw_tab = mk(6'h01, 1'b0, 1'b0, 2'h0, 4'h4, 4'h8, "FUNCTION");
        6'h08: kw_tab = mk(6'h00, 1'b0, 1'b0, 2'h0, 4'h4, 4'h6, "SOURCE");
        6'h09: kw_tab = mk(6'h08, 1'b0, 1'b0, 2'h0, 4'h4, 4'h9, "FREQUENCY");
        6'h0A: kw_tab = mk(6'h09, 1'b0, 1'b0, 2'h0, 4'h2, 4'h2, "CW");
        6'h0B: kw_tab = mk(6'h00, 1'b0, 1'b0, 2'h0, 4'h4, 4'h6, "STATUS");
        6'h0C: kw_tab = mk(6'h0B, 1'b0, 1'b0, 2'h0, 4'h4, 4'h9, "OPERATION");
        6'h0D: kw_tab = mk(6'h0C, 1'b0, 1'b0, 2'h2, 4'h4, 4'h9, "CONDITION");
        6'h0E: kw_tab = mk(6'h0C, 1'b1, 1'b0, 2'h2, 4'h4, 4'h5, "EVENT");
        6'h0F: kw_tab = mk(6'h00, 1'b0, 1'b0, 2'h0, 4'h4, 4'h6, "SYSTEM");
        6'h10: kw_tab = mk(6'h0F, 1'b0, 1'b0, 2'h2, 4'h3, 4'h5, "ERROR");
        6'h11: kw_tab = mk(6'h0F, 1'b0, 1'b0, 2'h1, 4'h4, 4'h6, "PRESET");
        6'h12: kw_tab = mk(6'h00, 1'b0, 1'b0, 2'h0, 4'h4, 4'h7, "TRIGGER");
        6'h13: kw_tab = mk(6'h12, 1'b0, 1'b0, 2'h0, 4'h3, 4'h5, "DELAY");
        6'h14: kw_tab = mk(6'h12, 1'b1, 1'b0, 2'h1, 4'h3, 4'h9, "IMMEDIATE");
        6'h15: kw_tab = mk(6'h00, 1'b0, 1'b0, 2'h1, 4'h4, 4'h5, "ABORT");
        6'h16: kw_tab = mk(6'h00, 1'b0, 1'b1, 2'h1, 4'h3, 4'h3, "CLS");
        6'h17: kw_tab = mk(6'h00, 1'b0, 1'b1, 2'h0, 4'h3, 4'h3, "ESE");
        6'h18: kw_tab = mk(6'h00, 1'b0, 1'b1, 2'h2, 4'h3, 4'h3, "ESR");
        6'h19: kw_tab = mk(6'h00, 1'b0, 1'b1, 2'h2, 4'h3, 4'h3, "IDN");
        6'h1A: kw_tab = mk(6'h00, 1'b0, 1'b1, 2'h2, 4'h3, 4'h3, "LRN");
        6'h1B: kw_tab = mk(6'h00, 1'b0, 1'b1, 2'h0, 4'h3, 4'h3, "OPC");
        6'h1C: kw_tab = mk(6'h00, 1'b0, 1'b1, 2'h2, 4'h3, 4'h3, "OPT");
        6'h1D: kw_tab = mk(6'h00, 1'b0, 1'b1, 2'h1, 4'h3, 4'h3, "RCL");
        6'h1E: kw_tab = mk(6'h00, 1'b0, 1'b1, 2'h1, 4'h3, 4'h3, "RST");
        6'h1F: kw_tab = mk(6'h00, 1'b0, 1'b1, 2'h1, 4'h3, 4'h3, "SAV");
        6'h20: kw_tab = mk(6'h00, 1'b0, 1'b1, 2'h0, 4'h3, 4'h3, "SRE");
        6'h21: kw_tab = mk(6'h00, 1'b0, 1'b1, 2'h2, 4'h3, 4'h3, "STB");
        6'h22: kw_tab = mk(6'h00, 1'b0, 1'b1, 2'h1, 4'h3, 4'h3, "TRG");
        6'h23: kw_tab = mk(6'h00, 1'b0, 1'b1, 2'h2, 4'h3, 4'h3, "TST");
        6'h24: kw_tab = mk(6'h00, 1'b0, 1'b1, 2'h1, 4'h3, 4'h3, "WAI");
        // the root never matches: its lengths are out of reach
        default: kw_tab = {6'h00, 1'b0, 1'b0, 2'h0, 4'hF, 4'hF, 80'h0};
      endcase
    end
  endfunction

  // ==========================================================
  // search: short or full length, compared over the held characters
  always @* begin
    m_hit = 1'b0;
    m_id = 6'h00;
    e = 98'h0;
    p = 98'h0;
    // one short form can name two nodes: the working node picks the one meant
    for (i = 0; i < `SCP_TAB_N; i = i + 1) begin
      e = kw_tab(i[5:0]);
      p = kw_tab(e[`SCP_F_PAR]);
      if (!m_hit && kw_len != 4'h0 && e[`SCP_F_COM] == kw_common &&
          (kw_common || e[`SCP_F_PAR] == kw_node ||
           (p[`SCP_F_OPT] && p[`SCP_F_PAR] == kw_node)) &&
          (kw_len == e[`SCP_F_SLEN] || kw_len == e[`SCP_F_FLEN]) &&
          (((kw_text ^ e[`SCP_F_TEXT]) & pre_mask(kw_len)) == 80'h0)) begin
        m_hit = 1'b1;
        m_id = i[5:0];
      end
    end
  end

  assign e_hit = kw_tab(m_id);
  assign e_par = kw_tab(e_hit[`SCP_F_PAR]);
  assign m_par = e_hit[`SCP_F_PAR];
  assign m_acc = e_hit[`SCP_F_ACC];
  assign m_popt = e_par[`SCP_F_OPT];
  assign m_gpar = e_par[`SCP_F_PAR];

endmodule

// *** design/scp_parser.v ***
// program message header parser with command-tree path tracking
`timescale 1ns/100ps
`include "scp_defines.vh"

module scp_parser (
  input wire clock,            // 250 MHz system clock
  input wire resetn,           // synchronous reset, active low
  input wire [7:0] rx_data,    // received bus data byte
  input wire rx_valid,         // rx_data holds a byte this cycle
  input wire rx_eoi,           // end indication with this byte
  input wire [7:0] resp_data,  // response byte from the instrument
  input wire resp_valid,       // resp_data holds a byte
  input wire resp_last,        // final byte of the response message
  output reg resp_ready_q,     // response byte taken when high
  output reg [7:0] tx_data_q,  // byte toward the bus
  output reg tx_valid_q,       // tx_data_q valid, one cycle
  output reg tx_eoi_q,         // end indication with tx_data_q
  output reg cmd_valid_q,      // one-cycle pulse: command resolved
  output reg cmd_err_q,        // one-cycle pulse: command error
  output reg [5:0] cmd_id_q,   // node or common command id
  output reg cmd_common_q,     // command was asterisk-prefixed
  output reg cmd_query_q,      // command was the query form
  output reg msg_end_q,        // one-cycle pulse: message ended
  output reg dev_reset_q,      // one-cycle pulse: reset command seen
  output reg [5:0] path_q      // current command-tree position
);

  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_HDR = 4'h2;
  localparam [3:0] S_PARAM = 4'h4;
  localparam [3:0] S_SKIP = 4'h8;

  reg [3:0] state_q;
  reg [5:0] work_q;
  reg [79:0] buf_q;
  reg [3:0] len_q;
  reg ovf_q;
  reg com_q;
  reg qry_q;
  reg [5:0] k_id_q;
  reg [5:0] k_par_q;
  reg [1:0] k_acc_q;
  reg [7:0] quote_q;
  reg nl_pend_q;

  function [7:0] to_upper;
    input [7:0] c;
    begin
      to_upper = (c >= 8'h61 && c <= 8'h7A) ? (c & ~`SCP_CASE_BIT) : c;
    end
  endfunction

  function is_alnum;
    input [7:0] c;
    begin
      is_alnum = (c >= 8'h41 && c <= 8'h5A) || (c >= 8'h30 && c <= 8'h39);
    end
  endfunction

  // ==========================================================
  // character classes
  wire [7:0] uc = to_upper(rx_data);
  wire in_hdr = (state_q == S_HDR);
  wire app = rx_valid && is_alnum(uc) && (state_q == S_IDLE || in_hdr);
  wire room = (len_q < `SCP_KW_MAX);
  wire ovf_nx = ovf_q | (app & ~room);
  wire [3:0] len_nx = (app && room) ? len_q + 4'h1 : len_q;
  wire [79:0] buf_nx = (app && room) ? (buf_q | ({72'h0, uc} << (8 * (9 - len_q)))) : buf_q;
  wire is_colon = (uc == `SCP_CH_COLON);
  wire is_semi = (uc == `SCP_CH_SEMI);
  wire is_qry = (uc == `SCP_CH_QUERY);
  wire is_space = (uc == `SCP_CH_SPACE);
  // newline, EOI on any byte, or both close the message
  wire msg_end = (uc == `SCP_CH_NL) || rx_eoi;

  // ==========================================================
  // keyword lookup on the buffer including this cycle's character
  wire m_hit;
  wire [5:0] m_id;
  wire [5:0] m_par;
  wire [1:0] m_acc;
  wire m_popt;
  wire [5:0] m_gpar;

  scp_kw_match u_match (
    .kw_text(buf_nx),
    .kw_len(len_nx),
    .kw_common(com_q),
    .kw_node(work_q),
    .m_hit(m_hit),
    .m_id(m_id),
    .m_par(m_par),
    .m_acc(m_acc),
    .m_popt(m_popt),
    .m_gpar(m_gpar)
  );

  // common commands ignore the working node entirely
  wire fin_ok = m_hit && !ovf_nx &&
                (com_q || m_par == work_q || (m_popt && m_gpar == work_q));

  // ==========================================================
  // command issue: from the header just closed or from the stored one
  wire i_ok = in_hdr ? fin_ok : 1'b1;
  wire [5:0] i_id = in_hdr ? m_id : k_id_q;
  wire [5:0] i_par = in_hdr ? m_par : k_par_q;
  wire [1:0] i_acc = in_hdr ? m_acc : k_acc_q;
  wire i_qry = in_hdr ? is_qry : qry_q;
  wire bad_form = (i_qry && i_acc == `SCP_ACC_NOQUERY) ||
                  (!i_qry && i_acc == `SCP_ACC_QONLY);
  wire i_good = i_ok && !bad_form;
  // path after a good non-common command is the level its header ended in; other common commands keep it, *RST sets root
  wire [5:0] path_nx = !i_good ? path_q :
                       (com_q && i_id == `SCP_CC_RST) ? `SCP_NODE_ROOT :
                       com_q ? path_q : i_par;
  wire cmd_end = (is_semi && quote_q == 8'h00) || msg_end;
  wire issue = rx_valid && cmd_end && (in_hdr || state_q == S_PARAM);

  // ==========================================================
  // parser state
  always @(posedge clock) begin
    if (!resetn) begin
      state_q <= S_IDLE;
      path_q <= `SCP_NODE_ROOT;
      work_q <= `SCP_NODE_ROOT;
      buf_q <= 80'h0;
      len_q <= 4'h0;
      ovf_q <= 1'b0;
      com_q <= 1'b0;
      qry_q <= 1'b0;
      k_id_q <= 6'h00;
      k_par_q <= 6'h00;
      k_acc_q <= 2'h0;
      quote_q <= 8'h00;
      cmd_valid_q <= 1'b0;
      cmd_err_q <= 1'b0;
      cmd_id_q <= 6'h00;
      cmd_common_q <= 1'b0;
      cmd_query_q <= 1'b0;
      msg_end_q <= 1'b0;
      dev_reset_q <= 1'b0;
    end else begin
      cmd_valid_q <= 1'b0;
      cmd_err_q <= 1'b0;
      msg_end_q <= 1'b0;
      dev_reset_q <= 1'b0;
      if (rx_valid) begin
        buf_q <= buf_nx;
        len_q <= len_nx;
        ovf_q <= ovf_nx;
        case (state_q)
          S_IDLE: begin
            if (app) begin
              state_q <= S_HDR;
            end else if (uc == `SCP_CH_STAR) begin
              com_q <= 1'b1;
              state_q <= S_HDR;
            end else if (is_colon) begin
              work_q <= `SCP_NODE_ROOT;
              state_q <= S_HDR;
            end else if (!is_space && !is_semi && !msg_end) begin
              cmd_err_q <= 1'b1;
              state_q <= S_SKIP;
            end
          end
          S_HDR: begin
            if (is_colon) begin
              buf_q <= 80'h0;
              len_q <= 4'h0;
              ovf_q <= 1'b0;
              if (fin_ok && !com_q) begin
                work_q <= m_id;
              end else begin
                cmd_err_q <= 1'b1;
                state_q <= S_SKIP;
              end
            end else if ((is_space || is_qry) && !msg_end) begin
              if (fin_ok) begin
                k_id_q <= m_id;
                k_par_q <= m_par;
                k_acc_q <= m_acc;
                qry_q <= is_qry;
                state_q <= S_PARAM;
              end else begin
                cmd_err_q <= 1'b1;
                state_q <= S_SKIP;
              end
            end else if (!app && !cmd_end) begin
              cmd_err_q <= 1'b1;
              state_q <= S_SKIP;
            end
          end
          S_PARAM: begin
            // a doubled delimiter closes and reopens, so it stays inside
            if (quote_q != 8'h00) begin
              if (rx_data == quote_q) begin
                quote_q <= 8'h00;
              end
            end else if (rx_data == `SCP_CH_SQUOTE || rx_data == `SCP_CH_DQUOTE) begin
              quote_q <= rx_data;
            end
          end
          S_SKIP: begin
            if (is_semi || msg_end) begin
              work_q <= path_q;
              state_q <= S_IDLE;
            end
          end
          default: state_q <= S_IDLE;
        endcase
        if (issue) begin
          cmd_valid_q <= i_good;
          cmd_err_q <= !i_good;
          cmd_id_q <= i_id;
          cmd_common_q <= com_q;
          cmd_query_q <= i_qry;
          dev_reset_q <= i_good && com_q && i_id == `SCP_CC_RST;
          path_q <= path_nx;
          work_q <= path_nx;
        end
        if (cmd_end || (state_q == S_SKIP && is_semi)) begin
          buf_q <= 80'h0;
          len_q <= 4'h0;
          ovf_q <= 1'b0;
          com_q <= 1'b0;
          qry_q <= 1'b0;
          quote_q <= 8'h00;
          if (state_q != S_IDLE || cmd_end) begin
            state_q <= S_IDLE;
          end
        end
        // the terminating byte is the message's last, whatever it carries
        if (msg_end) begin
          path_q <= `SCP_NODE_ROOT;
          work_q <= `SCP_NODE_ROOT;
          msg_end_q <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // response side: a newline with EOI follows the last byte
  always @(posedge clock) begin
    if (!resetn) begin
      resp_ready_q <= 1'b1;
      tx_data_q <= 8'h00;
      tx_valid_q <= 1'b0;
      tx_eoi_q <= 1'b0;
      nl_pend_q <= 1'b0;
    end else begin
      tx_valid_q <= 1'b0;
      tx_eoi_q <= 1'b0;
      if (nl_pend_q) begin
        tx_data_q <= `SCP_CH_NL;
        tx_valid_q <= 1'b1;
        tx_eoi_q <= 1'b1;
        nl_pend_q <= 1'b0;
        resp_ready_q <= 1'b1;
      end else if (resp_valid && resp_ready_q) begin
        tx_data_q <= resp_data;
        tx_valid_q <= 1'b1;
        if (resp_last) begin
          // hold off the next response until the terminator is out
          nl_pend_q <= 1'b1;
          resp_ready_q <= 1'b0;
        end
      end
    end
  end

endmodule

// *** verification/scp_chk.sv ***
// concurrent checks on the command path parser ports
`timescale 1ns/100ps
module scp_chk (
  input wire clock, // system clock
  input wire resetn, // sync reset, active low
  input wire [7:0] rx_data, // bus byte
  input wire rx_valid, // byte present
  input wire rx_eoi, // end indication
  input wire [7:0] resp_data, // response byte
  input wire resp_valid, // response present
  input wire resp_last, // last response byte
  input wire resp_ready_q, // response taken
  input wire [7:0] tx_data_q, // byte out
  input wire tx_valid_q, // byte out valid
  input wire tx_eoi_q, // end indication out
  input wire cmd_valid_q, // command pulse
  input wire cmd_err_q, // error pulse
  input wire [5:0] cmd_id_q, // command id
  input wire cmd_common_q, // common command
  input wire msg_end_q, // message end pulse
  input wire dev_reset_q, // reset command pulse
  input wire [5:0] path_q // tree position
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // path tracking
  chk_reset_root: assert property (disable iff (1'b0) !resetn |=> path_q == 6'h00)
    else $error("path not root after reset");
  chk_rst_cmd: assert property (dev_reset_q |-> cmd_common_q && cmd_id_q == 6'h1E)
    else $error("reset pulse without reset command");
  chk_nl_root: assert property (rx_valid && rx_data == 8'h0A
    |=> msg_end_q && path_q == 6'h00)
    else $error("newline did not end message");
  chk_eoi_end: assert property (rx_valid && rx_eoi |=> msg_end_q && path_q == 6'h00)
    else $error("eoi byte did not end message");
  chk_end_cause: assert property (msg_end_q
    |-> $past(rx_valid && (rx_data == 8'h0A || rx_eoi)))
    else $error("message end without terminator");
  chk_rst_pulse: assert property (cmd_valid_q && cmd_common_q && cmd_id_q == 6'h1E
    |-> dev_reset_q)
    else $error("reset command without reset pulse");
  chk_one_pulse: assert property (!(cmd_valid_q && cmd_err_q))
    else $error("command both good and in error");
  // ==========================================================
  // response path
  chk_resp_copy: assert property (resp_valid && resp_ready_q
    |=> tx_valid_q && tx_data_q == $past(resp_data))
    else $error("response byte not forwarded");
  chk_resp_term: assert property (resp_valid && resp_ready_q && resp_last
    |=> !resp_ready_q ##1 tx_valid_q && tx_eoi_q && tx_data_q == 8'h0A)
    else $error("response not ended by newline with eoi");
  chk_eoi_nl: assert property (tx_eoi_q |-> tx_valid_q && tx_data_q == 8'h0A)
    else $error("eoi out without newline");
endmodule

bind scp_parser scp_chk scp_chk_inst (.clock(clock), .resetn(resetn), .rx_data(rx_data),
  .rx_valid(rx_valid), .rx_eoi(rx_eoi), .resp_data(resp_data), .resp_valid(resp_valid),
  .resp_last(resp_last), .resp_ready_q(resp_ready_q), .tx_data_q(tx_data_q),
  .tx_valid_q(tx_valid_q), .tx_eoi_q(tx_eoi_q), .cmd_valid_q(cmd_valid_q),
  .cmd_err_q(cmd_err_q), .cmd_id_q(cmd_id_q), .cmd_common_q(cmd_common_q),
  .msg_end_q(msg_end_q), .dev_reset_q(dev_reset_q), .path_q(path_q));

// *** verification/scp_host.sv ***
// bus controller model sending program messages
`timescale 1ns/100ps
module scp_host (
  input wire clock, // system clock
  output reg [7:0] rx_data, // byte to parser
  output reg rx_valid, // byte present
  output reg rx_eoi // end indication
);
  initial begin
    rx_data = 8'hFF;
    rx_valid = 1'b0;
    rx_eoi = 1'b0;
  end
  // idle data is inverted so a stale byte never looks valid
  task idle;
    @(posedge clock);
    #1;
    rx_data = ~rx_data;
    rx_valid = 1'b0;
    rx_eoi = 1'b0;
  endtask
  // slow inserts an idle cycle after every byte
  task send(input string s, input bit eoi, input bit slow);
    int i;
    for (i = 0; i < s.len(); i++) begin
      @(posedge clock);
      #1;
      rx_data = s[i];
      rx_valid = 1'b1;
      rx_eoi = eoi && (i == s.len() - 1);
      if (slow) idle;
    end
    idle;
  endtask
endmodule

// *** verification/scpi_command_path_parser_test.sv ***
// self-checking bench for the command path parser
`timescale 1ns/100ps
module scpi_command_path_parser_test;
  localparam [9:0] Q = 10'h040;
  localparam [9:0] C = 10'h080;
  localparam [9:0] ER = 10'h100;
  reg clock;
  reg resetn;
  reg [7:0] resp_data;
  reg resp_valid;
  reg resp_last;
  wire [7:0] rx_data;
  wire rx_valid;
  wire rx_eoi;
  wire resp_ready_q, tx_valid_q, tx_eoi_q, cmd_valid_q, cmd_err_q;
  wire cmd_common_q, cmd_query_q, msg_end_q, dev_reset_q;
  wire [7:0] tx_data_q;
  wire [5:0] cmd_id_q;
  wire [5:0] path_q;
  integer seed;
  integer mismatches = 0;
  integer comparisons = 0;
  integer cycles = 0;
  integer k;
  string s;
  // events: bit 9 marks a bus byte {eoi,data}, else {err,common,query,id}
  reg [9:0] got_q[$];
  reg [9:0] exp_q[$];

  scp_host scp_host_inst (.clock(clock), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_eoi(rx_eoi));
  scp_parser scp_parser_inst (.clock(clock), .resetn(resetn), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_eoi(rx_eoi), .resp_data(resp_data), .resp_valid(resp_valid),
    .resp_last(resp_last), .resp_ready_q(resp_ready_q), .tx_data_q(tx_data_q),
    .tx_valid_q(tx_valid_q), .tx_eoi_q(tx_eoi_q), .cmd_valid_q(cmd_valid_q),
    .cmd_err_q(cmd_err_q), .cmd_id_q(cmd_id_q), .cmd_common_q(cmd_common_q),
    .cmd_query_q(cmd_query_q), .msg_end_q(msg_end_q), .dev_reset_q(dev_reset_q),
    .path_q(path_q));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // ==========================================================
  // monitor and timeout
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cmd_valid_q === 1'b1) got_q.push_back({1'b0, 1'b0, cmd_common_q, cmd_query_q, cmd_id_q});
    if (cmd_err_q === 1'b1) got_q.push_back(ER);
    if (tx_valid_q === 1'b1) got_q.push_back({1'b1, tx_eoi_q, tx_data_q});
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      $display("[ERR] %0t run did not complete", $time);
      end_of_test;
    end
  end
  // ==========================================================
  // helpers
  task end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task cmp(input [9:0] got, input [9:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task cmp_path(input [5:0] exp);
    comparisons = comparisons + 1;
    if (path_q !== exp) begin
      mismatches = mismatches + 1;
      $display("[ERR] %0t path %h expected %h", $time, path_q, exp);
    end
  endtask
  task e(input [9:0] v);
    exp_q.push_back(v);
  endtask
  task settle;
    repeat (4) @(posedge clock);
    cmp(10'(got_q.size()), 10'(exp_q.size()));
    while (got_q.size() > 0 && exp_q.size() > 0) cmp(got_q.pop_front(), exp_q.pop_front());
    got_q.delete();
    exp_q.delete();
  endtask
  task msg(input string m, input bit eoi);
    scp_host_inst.send(m, eoi, $random(seed) % 2);
    settle;
  endtask
  // random split into messages makes back-to-back last bytes meet the refusal cycle
  task resp(input int n);
    int i;
    #1;
    for (i = 0; i < n; i++) begin
      resp_data = $random(seed);
      resp_valid = 1'b1;
      resp_last = (i == n - 1) || ($random(seed) % 3 == 0);
      e({2'b10, resp_data});
      if (resp_last) e(10'h30A);
      @(posedge clock);
      while (resp_ready_q !== 1'b1) @(posedge clock);
      #1;
    end
    resp_valid = 1'b0;
    resp_last = 1'b0;
    resp_data = ~resp_data;
    settle;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    seed = 32'h28369aff;
    resetn = 1'b0;
    resp_valid = 1'b0;
    resp_last = 1'b0;
    resp_data = 8'h00;
    repeat (10) @(posedge clock);
    #1;
    resetn = 1'b1;
    e(10); msg(":SOUR:FREQ:CW 1\n", 0);
    e(10); msg("source:Frequency:cw 2\n", 0);
    e(Q | 16); e(Q | 16); msg("SYST:ERR?;ERR?", 1);
    e(10); e(Q | 16); msg("SOUR:FREQ:CW 1;:SYST:ERR?\n", 0);
    e(Q | 13); e(C | 22); e(Q | 13); msg("STAT:OPER:COND?;*CLS;COND?\n", 0);
    e(6); e(6); msg("FIMP:APER 1;:SENS:FIMP:APER 2\n", 1);
    e(ER); e(ER); e(ER); msg("SYST:ERR;:ABOR?;*RST?\n", 0);
    e(10); e(C | 30); e(ER); msg("SOUR:FREQ:CW 1;*RST;CW 2\n", 0);
    e(C | 22); msg("*cls", 1);
    e(ER); e(Q | 16); msg("FOO:BAR;:SYST:ERR?\n", 0);
    msg(";;\n", 0);
    e(10); msg("SOUR:FREQ:CW 1;", 0); cmp_path(6'h09);
    msg("\n", 0); cmp_path(6'h00);
    e(19); e(C | 22); msg(":TRIG:DEL 'a;b';*CLS\n", 0);
    for (k = 0; k < 16; k++) begin
      s = ":SOUR:FREQ:CW 1\n";
      foreach (s[j]) if (s[j] >= "A" && s[j] <= "Z" && $random(seed) % 2) s[j] = s[j] ^ 8'h20;
      e(10); msg(s, 0);
    end
    resp(12);
    scp_host_inst.send("SOUR:FREQ", 0, 0);
    resetn = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    resetn = 1'b1;
    e(ER); msg("CW 1\n", 0);
    end_of_test;
  end
endmodule
